// ==== occm_pkg.sv ====
// Shared constants and types for the channel-one output compare block
package occm_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int unsigned OCCM_ADDR_W = 8;
  localparam int unsigned OCCM_DATA_W = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OCCM_OFS_MODE1   = 8'h18;  // capture_compare_mode_reg_one
  localparam logic [7:0] OCCM_OFS_CTRL    = 8'h20;  // enable, polarity, trigger select
  localparam logic [7:0] OCCM_OFS_STATUS  = 8'h24;  // live channel state, read only
  localparam logic [7:0] OCCM_OFS_CMP     = 8'h34;  // ch1_compare_value (preload view)
  localparam logic [7:0] OCCM_OFS_CMP_ACT = 8'h38;  // active compare value, read only

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int unsigned OCCM_MD_SEL_LSB = 0;  // ch1_direction_select, 2 bits
  localparam int unsigned OCCM_MD_FEN     = 2;  // ch1_fast_trigger_enable
  localparam int unsigned OCCM_MD_PEN     = 3;  // ch1_compare_preload_enable
  localparam int unsigned OCCM_MD_MD_LSB  = 4;  // ch1_compare_mode, 3 bits
  localparam int unsigned OCCM_MD_CEN     = 7;  // ch1_reference_clear_enable
  localparam int unsigned OCCM_MD_CH2_LSB = 8;  // channel two byte, stored only

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned OCCM_CT_EN       = 0;  // ch1_channel_enable
  localparam int unsigned OCCM_CT_POL      = 1;  // ch1_output_polarity
  localparam int unsigned OCCM_CT_NPOL     = 2;  // complementary output polarity
  localparam int unsigned OCCM_CT_SINGLE_PULSE_MODE    = 3;  // single_pulse_mode
  localparam int unsigned OCCM_CT_TRIGGER_SOURCE_SELECT_LSB = 4;  // trigger_source_select, 3 bits
  localparam logic [2:0]  OCCM_TRIGGER_SOURCE_SELECT_INT_MAX = 3'h3;  // codes up to here are internal

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned OCCM_ST_REF   = 0;
  localparam int unsigned OCCM_ST_MATCH = 1;
  localparam int unsigned OCCM_ST_OUT   = 2;
  localparam int unsigned OCCM_ST_CAP   = 3;
  localparam int unsigned OCCM_ST_DOWN  = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] OCCM_RST_MODE1 = 16'h0000;
  localparam logic [15:0] OCCM_RST_CTRL  = 16'h0000;
  localparam logic [15:0] OCCM_RST_CMP   = 16'h0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OCCM_FROZEN    = 3'h0,
    OCCM_SET_MATCH = 3'h1,
    OCCM_CLR_MATCH = 3'h2,
    OCCM_TOGGLE    = 3'h3,
    OCCM_FORCE_LO  = 3'h4,
    OCCM_FORCE_HI  = 3'h5,
    OCCM_PWM1      = 3'h6,
    OCCM_PWM2      = 3'h7
  } occm_mode_t;

  typedef enum logic [1:0] {
    OCCM_DIR_OUT      = 2'h0,
    OCCM_DIR_IN_OWN   = 2'h1,
    OCCM_DIR_IN_OTHER = 2'h2,
    OCCM_DIR_IN_TRIG  = 2'h3
  } occm_dir_t;

endpackage

// ==== occm_compare_store.sv ====
// Compare value holding registers: software copy and the copy used by the comparator
`timescale 1ns/100ps
module occm_compare_store
  import occm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        preload_en,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  input  wire logic        update_event,
  output logic      [15:0] shadow,
  output logic      [15:0] active
);

  // ----------------------------------------------------------------
  // Software copy
  // ----------------------------------------------------------------
  // Every write lands here, so reads always return what was written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shadow <= OCCM_RST_CMP;
    end else if (wr) begin
      shadow <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Active copy
  // ----------------------------------------------------------------
  // Without preload the write goes straight through; with it, only updates
  always_ff @(posedge clk) begin
    if (!nrst) begin
      active <= OCCM_RST_CMP;
    end else if (wr && !preload_en) begin
      active <= wdata;
    end else if (update_event && preload_en) begin
      active <= shadow;
    end
  end

endmodule

// ==== occm_channel.sv ====
// Channel-one output compare mode logic with its register port
//
// Overview of operation
// - Frozen mode: comparisons leave reference untouched.
// - Mode 001: equality drives reference high.
// - Mode 010: equality drives reference low.
// - Mode 011: equality toggles the reference.
// - Mode 100: reference forced low always.
// - Mode 101: reference forced high always.
// - PWM1: high below compare counting up.
// - PWM2: low below compare counting up.
// - PWM reference moves on result change or leaving frozen.
// - Preload off: compare writes act at once.
// - Preload on: shadow copy loads on update.
// - Fast off: trigger does not touch reference.
// - Fast on: trigger edge acts as match.
// - Fast bit honoured only in PWM modes.
// - Direction field: output or three input maps.
// - Trigger mapping needs internal trigger selected.
// - Direction writable only while channel disabled.
// - Mode field bits 6:4 steer reference.
// - Reference active high; pins follow polarity.
// - Clear enable: external trigger forces reference low.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module occm_channel
  import occm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] timer_counter_value,
  input  wire logic        count_down,
  input  wire logic        update_event,
  input  wire logic        trigger_edge,
  input  wire logic        filtered_external_trigger,
  input  wire logic        timer_input_one,
  input  wire logic        timer_input_two,
  input  wire logic        internal_trigger_capture_source,
  output logic             ch1_output_reference,
  output logic             ch1_output,
  output logic             ch1_output_n,
  output logic             ch1_capture_input
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Shared by the normal PWM path and the fast trigger path
  function automatic logic pwm_level(input logic [2:0] mode,
                                     input logic       down,
                                     input logic       below,
                                     input logic       above);
    logic lvl1;
    lvl1 = down ? !above : below;  // PWM1 level
    if (mode == OCCM_PWM2) begin
      pwm_level = !lvl1;
    end else begin
      pwm_level = lvl1;
    end
  endfunction

  function automatic logic is_pwm(input logic [2:0] mode);
    is_pwm = (mode == OCCM_PWM1) || (mode == OCCM_PWM2);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] cmp_shadow;
  logic [15:0] cmp_active;

  // Named views of the fields
  logic [1:0]  ch1_direction_select;
  logic        ch1_fast_trigger_enable;
  logic        ch1_compare_preload_enable;
  logic [2:0]  ch1_compare_mode;
  logic        ch1_reference_clear_enable;
  logic        ch1_channel_enable;
  logic        ch1_output_polarity;
  logic        ch1_output_polarity_n;
  logic        single_pulse_mode;
  logic [2:0]  trigger_source_select;

  assign ch1_direction_select       = mode_reg[OCCM_MD_SEL_LSB +: 2];
  assign ch1_fast_trigger_enable    = mode_reg[OCCM_MD_FEN];
  assign ch1_compare_preload_enable = mode_reg[OCCM_MD_PEN];
  assign ch1_compare_mode           = mode_reg[OCCM_MD_MD_LSB +: 3];
  assign ch1_reference_clear_enable = mode_reg[OCCM_MD_CEN];
  assign ch1_channel_enable         = ctrl_reg[OCCM_CT_EN];
  assign ch1_output_polarity        = ctrl_reg[OCCM_CT_POL];
  assign ch1_output_polarity_n      = ctrl_reg[OCCM_CT_NPOL];
  assign single_pulse_mode          = ctrl_reg[OCCM_CT_SINGLE_PULSE_MODE];
  assign trigger_source_select      = ctrl_reg[OCCM_CT_TRIGGER_SOURCE_SELECT_LSB +: 3];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_mode;
  logic wr_ctrl;
  logic wr_cmp;

  assign wr_mode = reg_wr && (reg_addr == OCCM_OFS_MODE1);
  assign wr_ctrl = reg_wr && (reg_addr == OCCM_OFS_CTRL);
  assign wr_cmp  = reg_wr && (reg_addr == OCCM_OFS_CMP);

  // Mode register; the direction field is locked while the channel runs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= OCCM_RST_MODE1;
    end else if (wr_mode) begin
      mode_reg[15:2] <= reg_wdata[15:2];
      if (!ch1_channel_enable) begin
        mode_reg[OCCM_MD_SEL_LSB +: 2] <= reg_wdata[OCCM_MD_SEL_LSB +: 2];
      end
    end
  end

  // Control register; only defined bits are kept, the rest read zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= OCCM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= {9'h000, reg_wdata[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // Compare value store
  // ----------------------------------------------------------------
  // Write and update order is handled inside the store
  occm_compare_store u_store (
    .clk          (clk),
    .nrst         (nrst),
    .preload_en   (ch1_compare_preload_enable),
    .wr           (wr_cmp),
    .wdata        (reg_wdata),
    .update_event (update_event),
    .shadow       (cmp_shadow),
    .active       (cmp_active)
  );

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  logic cnt_equal;
  logic cnt_below;
  logic cnt_above;
  logic dir_is_output;

  assign cnt_equal     = (timer_counter_value == cmp_active);
  assign cnt_below     = (timer_counter_value < cmp_active);
  assign cnt_above     = (timer_counter_value > cmp_active);
  assign dir_is_output = (ch1_direction_select == OCCM_DIR_OUT);

  // ----------------------------------------------------------------
  // PWM history
  // ----------------------------------------------------------------
  // The last PWM level and mode are kept so the reference only moves
  // on a change of the comparison or on leaving frozen, never merely because it was forced
  logic pwm_now;
  logic pwm_fast;
  logic pwm_last;
  logic mode_was_frozen;

  assign pwm_now  = pwm_level(ch1_compare_mode, count_down, cnt_below, cnt_above);
  // Fast path evaluates as if the counter sat on the compare value
  assign pwm_fast = pwm_level(ch1_compare_mode, count_down, 1'b0, 1'b0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_last <= 1'b0;
    end else begin
      pwm_last <= pwm_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_was_frozen <= 1'b1;
    end else begin
      mode_was_frozen <= (ch1_compare_mode == OCCM_FROZEN);
    end
  end

  // ----------------------------------------------------------------
  // Reference next value
  // ----------------------------------------------------------------
  logic ref_q;
  logic next_ref;
  logic clear_now;
  logic fast_hit;

  assign clear_now = ch1_reference_clear_enable && filtered_external_trigger;
  // Fast bit is ignored outside PWM, and without it triggers do nothing
  assign fast_hit  = ch1_fast_trigger_enable && is_pwm(ch1_compare_mode)
                     && trigger_edge;

  always_comb begin
    next_ref = ref_q;
    case (ch1_compare_mode)
      OCCM_FROZEN: begin
        next_ref = ref_q;
      end
      OCCM_SET_MATCH: begin
        if (cnt_equal) begin
          next_ref = 1'b1;
        end
      end
      OCCM_CLR_MATCH: begin
        if (cnt_equal) begin
          next_ref = 1'b0;
        end
      end
      OCCM_TOGGLE: begin
        if (cnt_equal) begin
          next_ref = !ref_q;
        end
      end
      OCCM_FORCE_LO: begin
        next_ref = 1'b0;
      end
      OCCM_FORCE_HI: begin
        next_ref = 1'b1;
      end
      OCCM_PWM1, OCCM_PWM2: begin
        if (fast_hit) begin
          next_ref = pwm_fast;
        end else if ((pwm_now != pwm_last) || mode_was_frozen) begin
          next_ref = pwm_now;
        end
      end
      default: begin
        next_ref = ref_q;
      end
    endcase
    // Clear input overrides every mode
    if (clear_now) begin
      next_ref = 1'b0;
    end
    // Input channels never drive a compare reference
    if (!dir_is_output) begin
      next_ref = 1'b0;
    end
  end

  // Reference flop; one cycle from cause to level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= next_ref;
    end
  end

  assign ch1_output_reference = ref_q;

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Pins sit at their inactive level while the channel is off, so a
  // glitch cannot escape while software is still reconfiguring it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ch1_output   <= 1'b0;
      ch1_output_n <= 1'b0;
    end else if (ch1_channel_enable && dir_is_output) begin
      ch1_output   <= next_ref ^ ch1_output_polarity;
      ch1_output_n <= !next_ref ^ ch1_output_polarity_n;
    end else begin
      ch1_output   <= ch1_output_polarity;
      ch1_output_n <= ch1_output_polarity_n;
    end
  end

  // ----------------------------------------------------------------
  // Capture input mapping
  // ----------------------------------------------------------------
  logic trig_is_internal;
  logic next_capture;

  assign trig_is_internal = (trigger_source_select <= OCCM_TRIGGER_SOURCE_SELECT_INT_MAX);

  always_comb begin
    next_capture = 1'b0;
    case (ch1_direction_select)
      OCCM_DIR_OUT: begin
        next_capture = 1'b0;
      end
      OCCM_DIR_IN_OWN: begin
        next_capture = timer_input_one;
      end
      OCCM_DIR_IN_OTHER: begin
        next_capture = timer_input_two;
      end
      OCCM_DIR_IN_TRIG: begin
        // Without an internal trigger selected this mapping is inert
        next_capture = trig_is_internal && internal_trigger_capture_source;
      end
      default: begin
        next_capture = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ch1_capture_input <= 1'b0;
    end else begin
      ch1_capture_input <= next_capture;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] next_rdata;

  always_comb begin
    status_word = 16'h0000;
    status_word[OCCM_ST_REF]   = ref_q;
    status_word[OCCM_ST_MATCH] = cnt_equal;
    status_word[OCCM_ST_OUT]   = dir_is_output;
    status_word[OCCM_ST_CAP]   = ch1_capture_input;
    status_word[OCCM_ST_DOWN]  = count_down;
  end

  // Compare reads see the software copy, which is the preload when enabled
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      OCCM_OFS_MODE1: begin
        next_rdata = mode_reg;
      end
      OCCM_OFS_CTRL: begin
        next_rdata = ctrl_reg;
      end
      OCCM_OFS_STATUS: begin
        next_rdata = status_word;
      end
      OCCM_OFS_CMP: begin
        next_rdata = cmp_shadow;
      end
      OCCM_OFS_CMP_ACT: begin
        next_rdata = cmp_active;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Single-pulse flag is stored for the counter; preload advice is software's
  logic unused_single_pulse_mode;
  assign unused_single_pulse_mode = single_pulse_mode;

endmodule

// ==== occm_channel_props.sv ====
// Concurrent checks on the channel-one output compare ports
`timescale 1ns/100ps
module occm_channel_props
  import occm_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] timer_counter_value,
  input wire logic        count_down,
  input wire logic        update_event,
  input wire logic        trigger_edge,
  input wire logic        filtered_external_trigger,
  input wire logic        ch1_output_reference
);
  // ----------------------------------------------------------------
  // Register mirror
  // ----------------------------------------------------------------
  logic [15:0] md;
  logic        en;
  logic [15:0] shd;
  logic [15:0] act;
  logic [2:0]  mode;
  logic        ok;
  logic        eq;
  logic        pwm;
  logic        lvl;

  // Mode mirror; direction bits locked while enabled
  always_ff @(posedge clk) begin
    if (!nrst) begin
      md <= OCCM_RST_MODE1;
    end else if (reg_wr && reg_addr == OCCM_OFS_MODE1) begin
      md <= {reg_wdata[15:2], en ? md[1:0] : reg_wdata[1:0]};
    end
  end

  // Enable mirror
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en <= OCCM_RST_CTRL[0];
    end else if (reg_wr && reg_addr == OCCM_OFS_CTRL) begin
      en <= reg_wdata[0];
    end
  end

  // Compare mirror; an update moves the old shadow
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shd <= OCCM_RST_CMP;
      act <= OCCM_RST_CMP;
    end else begin
      if (reg_wr && reg_addr == OCCM_OFS_CMP) begin
        shd <= reg_wdata;
      end
      if (reg_wr && reg_addr == OCCM_OFS_CMP && !md[OCCM_MD_PEN]) begin
        act <= reg_wdata;
      end else if (update_event && md[OCCM_MD_PEN]) begin
        act <= shd;
      end
    end
  end

  // Decoded conditions; ok means output direction and no clear
  assign mode = md[6:4];
  assign ok   = md[1:0] == 2'h0 && !(md[7] && filtered_external_trigger);
  assign eq   = timer_counter_value == act;
  assign pwm  = mode[2] && mode[1];
  assign lvl  = (count_down ? timer_counter_value <= act
                            : timer_counter_value < act) ^ mode[0];

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  frozen_hold_a: assert property (mode == 3'h0 && ok
    |=> $stable(ch1_output_reference))
    else $error("reference moved in frozen mode");
  set_match_a: assert property (mode == 3'h1 && ok && eq |=> ch1_output_reference)
    else $error("reference not set on match");
  clr_match_a: assert property (mode == 3'h2 && eq |=> !ch1_output_reference)
    else $error("reference not cleared on match");
  toggle_match_a: assert property (mode == 3'h3 && ok && eq
    |=> ch1_output_reference != $past(ch1_output_reference))
    else $error("reference not toggled on match");
  force_low_a: assert property (mode == 3'h4 |=> !ch1_output_reference)
    else $error("reference not forced low");
  force_high_a: assert property (mode == 3'h5 && ok |=> ch1_output_reference)
    else $error("reference not forced high");
  pwm_follow_a: assert property (pwm && ok && !trigger_edge
    && mode == $past(mode) && lvl != $past(lvl) |=> ch1_output_reference == $past(lvl))
    else $error("pwm reference missed a level change");
  pwm_start_a: assert property (pwm && ok && !trigger_edge && $past(mode) == 3'h0
    |=> ch1_output_reference == $past(lvl))
    else $error("pwm reference wrong after leaving frozen");
  fast_trig_a: assert property (pwm && md[OCCM_MD_FEN] && trigger_edge
    && ok && !count_down |=> ch1_output_reference == $past(mode[0]))
    else $error("fast trigger did not act as match");
  clear_ref_a: assert property (md[7] && filtered_external_trigger
    |=> !ch1_output_reference)
    else $error("reference not cleared by external trigger");
  mode_read_a: assert property (reg_rd && reg_addr == OCCM_OFS_MODE1
    |=> reg_rdata == $past(md))
    else $error("mode register read back wrong");
endmodule

bind occm_channel occm_channel_props u_props (
  .clk                       (clk),
  .nrst                      (nrst),
  .reg_addr                  (reg_addr),
  .reg_wdata                 (reg_wdata),
  .reg_wr                    (reg_wr),
  .reg_rd                    (reg_rd),
  .reg_rdata                 (reg_rdata),
  .timer_counter_value       (timer_counter_value),
  .count_down                (count_down),
  .update_event              (update_event),
  .trigger_edge              (trigger_edge),
  .filtered_external_trigger (filtered_external_trigger),
  .ch1_output_reference      (ch1_output_reference)
);

// ==== occm_channel_tb.sv ====
// Self-checking bench for the channel-one output compare block
`timescale 1ns/100ps
module occm_channel_tb
  import occm_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] cnt;
  logic        dn;
  logic        upd;
  logic        trg;
  logic        etr;
  logic [2:0]  src;
  logic        ref_o;
  logic        pin;
  logic        pin_n;
  logic        cap;
  int          failures = 0;
  int          n_checks = 0;
  logic [2:0]  tm [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h3};
  logic        te [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  logic [15:0] pc [3] = '{16'h001F, 16'h0021, 16'h0020};
  logic        pd [3] = '{1'h0, 1'h1, 1'h1};
  logic        pe [3] = '{1'h1, 1'h0, 1'h1};

  occm_channel uut (
    .clk                             (clk),
    .nrst                            (nrst),
    .reg_addr                        (reg_addr),
    .reg_wdata                       (reg_wdata),
    .reg_wr                          (reg_wr),
    .reg_rd                          (reg_rd),
    .reg_rdata                       (reg_rdata),
    .timer_counter_value             (cnt),
    .count_down                      (dn),
    .update_event                    (upd),
    .trigger_edge                    (trg),
    .filtered_external_trigger       (etr),
    .timer_input_one                 (src[0]),
    .timer_input_two                 (src[1]),
    .internal_trigger_capture_source (src[2]),
    .ch1_output_reference            (ref_o),
    .ch1_output                      (pin),
    .ch1_output_n                    (pin_n),
    .ch1_capture_input               (cap)
  );

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    check(n, reg_rdata, e);
  endtask

  // Let one edge act, then compare the reference
  task automatic cr(input logic e);
    @(posedge clk);
    #1;
    check("reference", 16'(ref_o), 16'(e));
  endtask

  // One-cycle trigger pulse, reference looked at after it
  task automatic tp(input logic e);
    @(posedge clk);
    trg <= 1'h1;
    @(posedge clk);
    trg <= 1'h0;
    #1;
    check("trigger reference", 16'(ref_o), 16'(e));
  endtask

  // Watchdog sized well above the roughly 110 cycles used
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    final_report;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, reg_wr, reg_rd, dn, upd, trg, etr} = 7'h00;
    {reg_addr, reg_wdata, cnt, src} = 43'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    rd(OCCM_OFS_MODE1, 16'h0000, "mode reset");
    rd(8'h3C, 16'h0000, "unmapped read");
    // Enabled channel, preload off, then a direction write that must bounce
    wr(OCCM_OFS_CTRL, 16'h0001);
    wr(OCCM_OFS_CMP, 16'h0010);
    rd(OCCM_OFS_CMP_ACT, 16'h0010, "active compare");
    wr(OCCM_OFS_MODE1, 16'h0051);
    rd(OCCM_OFS_MODE1, 16'h0050, "locked direction");
    check("main pin", 16'(pin), 16'h0001);
    check("comp pin", 16'(pin_n), 16'h0000);
    // Frozen, match and forced-low modes with the counter on the match value
    @(posedge clk);
    cnt <= 16'h0010;
    foreach (tm[i]) begin
      wr(OCCM_OFS_MODE1, {9'h000, tm[i], 4'h0});
      cr(te[i]);
    end
    cr(1'h0);
    // Clear input beats a forced-high level only while it is high
    wr(OCCM_OFS_MODE1, 16'h00D0);
    etr <= 1'h1;
    cr(1'h0);
    @(posedge clk);
    etr <= 1'h0;
    cr(1'h1);
    rd(OCCM_OFS_STATUS, 16'h0007, "status");
    // Preload holds the new value back until the update pulse
    wr(OCCM_OFS_MODE1, 16'h0008);
    wr(OCCM_OFS_CMP, 16'h0020);
    rd(OCCM_OFS_CMP_ACT, 16'h0010, "held compare");
    rd(OCCM_OFS_CMP, 16'h0020, "preload compare");
    @(posedge clk);
    upd <= 1'h1;
    cnt <= 16'h0020;
    @(posedge clk);
    upd <= 1'h0;
    rd(OCCM_OFS_CMP_ACT, 16'h0020, "loaded compare");
    wr(OCCM_OFS_MODE1, 16'h0068);
    cr(1'h0);
    foreach (pc[i]) begin
      @(posedge clk);
      cnt <= pc[i];
      dn  <= pd[i];
      cr(pe[i]);
    end
    wr(OCCM_OFS_MODE1, 16'h0008);
    wr(OCCM_OFS_MODE1, 16'h0078);
    cr(1'h0);
    @(posedge clk);
    dn <= 1'h0;
    cr(1'h1);
    // Trigger path: fast off, fast in a non-PWM mode, fast on
    wr(OCCM_OFS_MODE1, 16'h0068);
    @(posedge clk);
    cnt <= 16'h001F;
    cr(1'h1);
    tp(1'h1);
    wr(OCCM_OFS_MODE1, 16'h002C);
    tp(1'h1);
    wr(OCCM_OFS_MODE1, 16'h006C);
    tp(1'h0);
    // Input maps with the channel off; the chosen source high alone, then low alone
    wr(OCCM_OFS_CTRL, 16'h0002);
    for (int d = 1; d < 4; d++) begin
      wr(OCCM_OFS_MODE1, 16'(d));
      src <= 3'h1 << (d - 1);
      repeat (2) @(posedge clk);
      #1;
      check("capture high", 16'(cap), 16'h0001);
      @(posedge clk);
      src <= ~(3'h1 << (d - 1));
      repeat (2) @(posedge clk);
      #1;
      check("capture low", 16'(cap), 16'h0000);
    end
    // External trigger source selected: the trigger mapping must stay inert
    wr(OCCM_OFS_CTRL, 16'h0042);
    src <= 3'h4;
    repeat (2) @(posedge clk);
    #1;
    check("capture inert", 16'(cap), 16'h0000);
    check("idle pin", 16'(pin), 16'h0001);
    final_report;
  end
endmodule
